// ==== hdl/cpg_clock_pulse_gen.v ====
// What this block does
// - bus clock ratio from three-bit field
// - faster bus setting runs at system rate
// - fixed times-four multiplication, not programmable
// - divider phase locked to crystal input edges
// - divide pll clock by one, two, four, eight
// - apply after bus cycle, within input cycle
// - system clock never slower than others
// - peripherals on peripheral clock, dma on system
// - separate system and peripheral ratio fields
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`include "cpg_defs.vh"

module cpg_clock_pulse_gen (
    // clock and reset (mclk_i is the pll output)
    input wire mclk_i,
    input wire rst_i,
    // pins and system status
    input wire crystal_input_pin_i,
    input wire bus_cycle_busy_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    // derived clock enables
    output reg core_clk_en_o,
    output reg periph_clk_en_o,
    output reg bus_clk_en_o
);

    // ****************************************
    // constants
    // ****************************************
    // whole reset word; each field is sliced from it on purpose
    localparam [15:0] RATIO_RST = `CPG_RATIO_RESET;
    // last divider phase of one input period
    localparam integer LAST_PH_INT = `CPG_PLL_MULT - 1;
    localparam [1:0] LAST_PH = LAST_PH_INT[1:0];

    // ****************************************
    // ratio helpers
    // ****************************************
    // larger code is slower; the system code caps the others
    function [2:0] cap_ratio;
        input [2:0] code;
        input [2:0] core;
        begin
            cap_ratio = (code < core) ? core : code;
        end
    endfunction

    // one-cycle enable for a code at divider phase cnt
    function ratio_pulse;
        input [2:0] code;
        input [2:0] cnt;
        begin
            case (code)
                `CPG_CODE_X4: ratio_pulse = 1'b1;
                `CPG_CODE_X2: ratio_pulse = cnt[0];
                `CPG_CODE_X1: ratio_pulse = &cnt[1:0];
                `CPG_CODE_XHALF: ratio_pulse = &cnt;
                default: ratio_pulse = 1'b0;
            endcase
        end
    endfunction

    // prohibited codes leave the field unchanged
    function [2:0] legal_field;
        input [2:0] new_code;
        input [2:0] old_code;
        begin
            legal_field = new_code[2] ? old_code : new_code;
        end
    endfunction

    // status word: pending flag and the capped ratios in force
    function [31:0] status_word;
        input busy_flag;
        input [2:0] core;
        input [2:0] periph;
        input [2:0] bus;
        begin
            status_word = {16'h0000, 3'h0, busy_flag, 1'b0, core,
                1'b0, periph, 1'b0, bus};
        end
    endfunction

    // word decode shared by the write and read paths
    function reg_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            reg_hit = (addr == offset);
        end
    endfunction

    // ****************************************
    // registers and state
    // ****************************************
    reg [15:0] ratio_ctrl;
    reg [2:0] core_act;
    reg [2:0] periph_act;
    reg [2:0] bus_act;
    reg pending;
    reg [2:0] div_cnt;
    reg xin_s1;
    reg xin_s2;
    reg xin_s3;
    reg wr_phase;
    reg [31:0] rdata;
    reg [15:0] next_ratio;
    reg [2:0] next_cnt;
    reg [2:0] per_cap;
    reg [2:0] bus_cap;
    wire addr_take;
    wire wr_now;
    wire xin_rise;
    wire input_edge;
    wire apply_now;
    wire [31:0] status_now;
    wire [2:0] pulse_next;
    wire [8:0] eff_codes;
    reg [31:0] next_rdata;

    // ****************************************
    // ahb-lite slave
    // ****************************************
    // zero wait states: every transfer completes in one data phase
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata;
    assign addr_take = hsel_i & htrans_i[1] & hready_i;

    always @* begin
        next_rdata = 32'h00000000;
        if (addr_take & ~hwrite_i) begin
            if (reg_hit(haddr_i, `CPG_ADDR_RATIO)) begin
                next_rdata = {16'h0000, ratio_ctrl};
            end else if (reg_hit(haddr_i, `CPG_ADDR_STATUS)) begin
                next_rdata = status_now;
            end
        end
    end

    // read data stands for the data phase only, then returns to zero
    always @(posedge mclk_i) begin
        if (rst_i) begin
            wr_phase <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            wr_phase <= addr_take & hwrite_i
                & reg_hit(haddr_i, `CPG_ADDR_RATIO);
            rdata <= next_rdata;
        end
    end

    assign wr_now = wr_phase;

    always @* begin
        next_ratio = 16'h0000;
        next_ratio[`CPG_CORE_MSB:`CPG_CORE_LSB] = legal_field(
            hwdata_i[`CPG_CORE_MSB:`CPG_CORE_LSB],
            ratio_ctrl[`CPG_CORE_MSB:`CPG_CORE_LSB]);
        next_ratio[`CPG_PERIPH_MSB:`CPG_PERIPH_LSB] = legal_field(
            hwdata_i[`CPG_PERIPH_MSB:`CPG_PERIPH_LSB],
            ratio_ctrl[`CPG_PERIPH_MSB:`CPG_PERIPH_LSB]);
        next_ratio[`CPG_BUS_MSB:`CPG_BUS_LSB] = legal_field(
            hwdata_i[`CPG_BUS_MSB:`CPG_BUS_LSB],
            ratio_ctrl[`CPG_BUS_MSB:`CPG_BUS_LSB]);
    end

    // ****************************************
    // divider and phase alignment
    // ****************************************
    // crystal input comes from off-chip: two flops before use
    always @(posedge mclk_i) begin
        if (rst_i) begin
            xin_s1 <= 1'b0;
            xin_s2 <= 1'b0;
            xin_s3 <= 1'b0;
        end else begin
            xin_s1 <= crystal_input_pin_i;
            xin_s2 <= xin_s1;
            xin_s3 <= xin_s2;
        end
    end

    assign xin_rise = xin_s2 & ~xin_s3;
    // limitation: the pin must run at a quarter of mclk_i, otherwise
    // every input edge drags the divider phase around

    always @* begin
        next_cnt = div_cnt + 3'h1;
        if (xin_rise) begin
            next_cnt[1:0] = `CPG_ALIGN_PHASE;
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= next_cnt;
        end
    end

    // input period is a fixed four pll cycles
    assign input_edge = (div_cnt[1:0] == LAST_PH);

    // ****************************************
    // ratio change sequencing
    // ****************************************
    // wait for bus idle and input edge
    assign apply_now = pending & ~bus_cycle_busy_i & input_edge;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            ratio_ctrl <= `CPG_RATIO_RESET;
            pending <= 1'b0;
            core_act <= RATIO_RST[`CPG_CORE_MSB:`CPG_CORE_LSB];
            periph_act <= RATIO_RST[`CPG_PERIPH_MSB:`CPG_PERIPH_LSB];
            bus_act <= RATIO_RST[`CPG_BUS_MSB:`CPG_BUS_LSB];
        end else begin
            if (wr_now) begin
                ratio_ctrl <= next_ratio;
            end
            // a write in the apply cycle keeps the change pending;
            // the set wins so that no written value is ever lost
            pending <= wr_now | (pending & ~apply_now);
            if (apply_now) begin
                core_act <= ratio_ctrl[`CPG_CORE_MSB:`CPG_CORE_LSB];
                periph_act <=
                    ratio_ctrl[`CPG_PERIPH_MSB:`CPG_PERIPH_LSB];
                bus_act <= ratio_ctrl[`CPG_BUS_MSB:`CPG_BUS_LSB];
            end
        end
    end

    // ****************************************
    // clock enable outputs
    // ****************************************
    // system setting has priority
    always @* begin
        per_cap = cap_ratio(periph_act, core_act);
        bus_cap = cap_ratio(bus_act, core_act);
    end

    // ****************************************
    // status word
    // ****************************************
    // software sees the rates really in force, after capping
    assign status_now = status_word(pending, core_act, per_cap, bus_cap);

    // ****************************************
    // per-clock pulse selection
    // ****************************************
    // one decoder per derived clock, all on the same divider phase
    assign eff_codes = {core_act, per_cap, bus_cap};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_pulse
            assign pulse_next[gi] = ratio_pulse(
                eff_codes[gi*3+2:gi*3], next_cnt);
        end
    endgenerate

    // registered one-cycle pulses only
    // switching at an input edge keeps periods of one, two and four cycles whole, but can cut an eight-cycle period short
    always @(posedge mclk_i) begin
        if (rst_i) begin
            core_clk_en_o <= 1'b0;
            periph_clk_en_o <= 1'b0;
            bus_clk_en_o <= 1'b0;
        end else begin
            // cpu, dma and transfer controller enable
            core_clk_en_o <= pulse_next[2];
            periph_clk_en_o <= pulse_next[1];
            bus_clk_en_o <= pulse_next[0];
        end
    end

endmodule // cpg_clock_pulse_gen

// ==== shared/cpg_defs.vh ====
`ifndef CPG_DEFS_VH
`define CPG_DEFS_VH

// ****************************************
// register map
// ****************************************
`define CPG_ADDR_RATIO 8'h00
`define CPG_ADDR_STATUS 8'h04
`define CPG_RATIO_RESET 16'h0222

// ****************************************
// field positions in clock_ratio_control
// ****************************************
`define CPG_CORE_MSB 10
`define CPG_CORE_LSB 8
`define CPG_PERIPH_MSB 6
`define CPG_PERIPH_LSB 4
`define CPG_BUS_MSB 2
`define CPG_BUS_LSB 0

// ****************************************
// ratio codes and timing
// ****************************************
`define CPG_CODE_X4 3'h0
`define CPG_CODE_X2 3'h1
`define CPG_CODE_X1 3'h2
`define CPG_CODE_XHALF 3'h3
`define CPG_PLL_MULT 4
`define CPG_ALIGN_PHASE 2'h2

`endif

// ==== verification/cpg_chk_sva.sv ====
`timescale 1ns/10ps
module cpg_chk (
    input wire mclk_i,
    input wire rst_i,
    input wire hsel_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire [1:0] htrans_i,
    input wire [7:0] haddr_i,
    input wire [31:0] hrdata_o,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire core_clk_en_o,
    input wire periph_clk_en_o,
    input wire bus_clk_en_o
);
    reg rd = 1'b0;
    reg [7:0] ad = 8'h00;
    always @(posedge mclk_i) begin
        rd <= hsel_i && htrans_i[1] && hready_i && !hwrite_i;
        ad <= haddr_i;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    bus_okay_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not okay");
    idle_zero_a: assert property (!rd |-> hrdata_o == 32'h0)
        else $error("read data outside data phase");
    rsvd_zero_a: assert property (rd && ad == 8'h00 |->
        hrdata_o[31:11] == 0 && !hrdata_o[7] && !hrdata_o[3])
        else $error("reserved bits set");
    unmapped_zero_a: assert property (rd && ad[7:3] != 0 |-> hrdata_o == 0)
        else $error("unmapped read not zero");
    legal_code_a: assert property (rd && ad == 8'h04 |->
        !hrdata_o[10] && !hrdata_o[6] && !hrdata_o[2])
        else $error("prohibited code active");
    core_first_a: assert property (rd && ad == 8'h04 |->
        hrdata_o[6:4] >= hrdata_o[10:8] && hrdata_o[2:0] >= hrdata_o[10:8])
        else $error("slower core than others");
    periph_core_a: assert property (periph_clk_en_o |-> core_clk_en_o)
        else $error("periph pulse without core");
    bus_core_a: assert property (bus_clk_en_o |-> core_clk_en_o)
        else $error("bus pulse without core");
    core_gap_a: assert property (core_clk_en_o |=> ##[0:11] core_clk_en_o)
        else $error("core pulse missing");
    cover property (core_clk_en_o ##1 core_clk_en_o);
    cover property (rd && ad == 8'h04);
    cover property (bus_clk_en_o && !periph_clk_en_o);
endmodule // cpg_chk
bind cpg_clock_pulse_gen cpg_chk u_chk (.*);

// ==== verification/cpg_clock_pulse_gen_test.sv ====
`timescale 1ns/10ps
module cpg_clock_pulse_gen_test;
    reg mclk_i = 1'b0;
    reg rst_i = 1'b1;
    reg busy = 1'b0;
    reg hsel = 1'b0;
    reg hwrite = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [7:0] haddr = 8'h00;
    reg [31:0] hwdata = 32'h0;
    reg [31:0] rdat;
    wire [31:0] hrdata;
    wire hrdy, pin, ce, pe, be;
    int err_total = 0, check_count = 0, cyc = 0, n;
    initial forever #5 mclk_i = ~mclk_i;
    cpg_crystal_output_pin_src src (.mclk_i(mclk_i), .standby_i(1'b0), .pin_o(pin));
    cpg_clock_pulse_gen uut (.mclk_i(mclk_i), .rst_i(rst_i),
        .crystal_input_pin_i(pin), .bus_cycle_busy_i(busy), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(),
        .core_clk_en_o(ce), .periph_clk_en_o(pe), .bus_clk_en_o(be));
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task xfer(input w, input [7:0] a, input [31:0] d);
        @(posedge mclk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk_i); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk_i); while (hrdy !== 1'b1);
        rdat = hrdata;
        @(posedge mclk_i);
    endtask
    // polls status until the pending change has landed
    task settle;
        n = 0;
        do begin
            xfer(0, 8'h04, 0);
            n++;
        end while (rdat[12] !== 1'b0 && n < 20);
    endtask
    task gap(output int g);
        g = 0;
        do @(negedge mclk_i); while (be !== 1'b1);
        do begin
            @(negedge mclk_i);
            g++;
        end while (be !== 1'b1);
    endtask
    task reset_vals;
        xfer(0, 8'h00, 0);
        chk(rdat, 32'h0222);
        xfer(0, 8'h04, 0);
        chk(rdat, 32'h0222);
        xfer(0, 8'h08, 0);
        chk(rdat, 32'h0);
    endtask
    task ratio_walk;
        for (int c = 0; c < 4; c++) begin
            xfer(1, 8'h00, (c << 4) | c);
            settle;
            chk(rdat, (c << 4) | c);
            gap(n);
            chk(n, 1 << c);
        end
    endtask
    task refuse_code;
        xfer(1, 8'h00, 32'h0214);
        xfer(0, 8'h00, 0);
        chk(rdat, 32'h0213);
        settle;
        chk(rdat, 32'h0223);
        gap(n);
        chk(n, 8);
    endtask
    task core_cap;
        xfer(1, 8'h00, 32'h0300);
        settle;
        chk(rdat, 32'h0333);
        gap(n);
        chk(n, 8);
    endtask
    task busy_hold;
        @(posedge mclk_i);
        busy <= 1'b1;
        xfer(1, 8'h00, 32'h0222);
        repeat (8) xfer(0, 8'h04, 0);
        chk(rdat, 32'h1333);
        @(posedge mclk_i);
        busy <= 1'b0;
        // a change may wait one crystal period once the bus is idle
        repeat (4) @(posedge mclk_i);
        xfer(0, 8'h04, 0);
        chk(rdat, 32'h0222);
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        reset_vals;
        ratio_walk;
        refuse_code;
        core_cap;
        busy_hold;
        wrap_up;
    end
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up;
        end
    end
endmodule // cpg_clock_pulse_gen_test

// ==== verification/cpg_crystal_output_pin_src.sv ====
`timescale 1ns/10ps
module cpg_crystal_output_pin_src (
    input wire mclk_i,
    input wire standby_i,
    output reg pin_o = 1'b1
);
    reg [1:0] ph = 2'h0;
    always @(posedge mclk_i) begin
        ph <= ph + 2'h1;
        pin_o <= standby_i | ~ph[1];
    end
endmodule // cpg_crystal_output_pin_src
